// File: design/bdc_pkg.sv
package bdc_pkg;

    // Dword address holding both registers
    localparam logic [7:0] BDC_DWORD_ADDR   = 8'h40;
    localparam logic [7:0] BDC_CHIP_CTL_OFS = 8'h40;
    localparam logic [7:0] BDC_DIAG_CTL_OFS = 8'h41;

    // Field positions within the dword, and the GPIO bit sensed for live insertion
    localparam int BDC_MW_CTL_BIT    = 1;
    localparam int BDC_PF_DIS_BIT    = 4;
    localparam int BDC_LIVE_INS_BIT  = 5;
    localparam int BDC_CHIP_RST_BIT  = 8;
    localparam int BDC_TEST_MODE_LSB = 9;
    localparam int BDC_GPIO_LIVE_BIT = 3;

    // Reset values
    localparam logic       BDC_MW_CTL_RST    = 1'h0;
    localparam logic       BDC_PF_DIS_RST    = 1'h0;
    localparam logic       BDC_LIVE_INS_RST  = 1'h0;
    localparam logic [1:0] BDC_TEST_MODE_RST = 2'h0;

    // Chip reset pulse length, in cycles of the core clock
    localparam int BDC_CHIP_RST_NS     = 500;
    localparam int BDC_CLK_NS          = 50;
    localparam int BDC_CHIP_RST_CYCLES =
        (BDC_CHIP_RST_NS + BDC_CLK_NS - 1) / BDC_CLK_NS;

    // Counter byte selection
    typedef enum logic [1:0] {
        BDC_TM_ALL   = 2'h0,
        BDC_TM_BYTE1 = 2'h1,
        BDC_TM_BYTE2 = 2'h2,
        BDC_TM_BYTE0 = 2'h3
    } bdc_test_mode_t;

    // Memory read command kinds
    typedef enum logic [1:0] {
        BDC_RD_PLAIN = 2'h0,
        BDC_RD_LINE  = 2'h1,
        BDC_RD_MULT  = 2'h2
    } bdc_rd_kind_t;

    // Configuration access from the primary target
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [3:0]  cbe_n;
        logic [31:0] wdata;
    } bdc_cfg_req_t;

    // Steering outputs for the datapath
    typedef struct packed {
        logic       disc_cache_line;
        logic       prefetch;
        logic       fwd_byte_en;
        logic       single_dword;
        logic       disc_first;
        logic [3:0] cnt_byte_sel;
    } bdc_steer_t;

endpackage : bdc_pkg

// File: design/bdc_regs.sv
`timescale 1ns/10ps
module bdc_regs
    import bdc_pkg::*;
#(
    parameter int RST_CYCLES = BDC_CHIP_RST_CYCLES
) (
    // Clock and reset
    input  wire logic         CORE_CLK,
    input  wire logic         RESETN,
    // Configuration access
    input  wire bdc_cfg_req_t CFG_REQ,
    output logic [31:0]       CFG_RDATA,
    // Upstream read command
    input  wire bdc_rd_kind_t RD_KIND,
    // Live insertion inputs
    input  wire logic         GPIO3_IN,
    input  wire logic         GPIO3_OE,
    input  wire logic         IO_EN,
    input  wire logic         MEM_EN,
    input  wire logic         MASTER_EN,
    // Gated enables
    output logic              IO_EN_EFF,
    output logic              MEM_EN_EFF,
    output logic              MASTER_EN_EFF,
    // Datapath steering
    output bdc_steer_t        STEER,
    // Reset outputs
    output logic              CHIP_RST,
    output logic              SEC_RST_SET
);

    logic       mw_ctl_q;
    logic       pf_dis_q;
    logic       live_ins_q;
    logic [1:0] test_mode_q;
    logic       chip_rst_q;
    logic [7:0] rst_cnt_q;
    logic [7:0] rst_cnt_d;
    logic [31:0] rdata_q;

    // Address and byte lane decode
    wire hit     = (CFG_REQ.addr == BDC_DWORD_ADDR);
    wire wr_b0   = CFG_REQ.wr && hit && !CFG_REQ.cbe_n[0];
    wire wr_b1   = CFG_REQ.wr && hit && !CFG_REQ.cbe_n[1];
    wire rd_hit  = CFG_REQ.rd && hit;
    wire rst_go  = wr_b1 && CFG_REQ.wdata[BDC_CHIP_RST_BIT];
    wire rst_end = chip_rst_q && (rst_cnt_q == 8'h01);

    // Byte 0 fields; writes ignored while chip reset runs
    always_ff @(posedge CORE_CLK) begin
        if (!RESETN || chip_rst_q) begin
            mw_ctl_q   <= BDC_MW_CTL_RST;
            pf_dis_q   <= BDC_PF_DIS_RST;
            live_ins_q <= BDC_LIVE_INS_RST;
        end else if (wr_b0) begin
            mw_ctl_q   <= CFG_REQ.wdata[BDC_MW_CTL_BIT];
            pf_dis_q   <= CFG_REQ.wdata[BDC_PF_DIS_BIT];
            live_ins_q <= CFG_REQ.wdata[BDC_LIVE_INS_BIT];
        end
    end

    // Byte 1 test mode field
    always_ff @(posedge CORE_CLK) begin
        if (!RESETN || chip_rst_q) begin
            test_mode_q <= BDC_TEST_MODE_RST;
        end else if (wr_b1) begin
            test_mode_q <= CFG_REQ.wdata[BDC_TEST_MODE_LSB +: 2];
        end
    end

    // Chip reset counter reload and count down
    assign rst_cnt_d = rst_go ? 8'(RST_CYCLES) :
                       (chip_rst_q ? rst_cnt_q - 8'h01 : rst_cnt_q);

    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            chip_rst_q <= 1'b0;
            rst_cnt_q  <= 8'h00;
        end else begin
            rst_cnt_q <= rst_cnt_d;
            if (rst_go) begin
                chip_rst_q <= 1'b1;
            end else if (rst_end) begin
                chip_rst_q <= 1'b0;
            end
        end
    end

    // Read data, all byte lanes, reserved bits zero
    wire [31:0] rd_word = {
        16'h0000,
        5'h00, test_mode_q, chip_rst_q,
        2'h0, live_ins_q, pf_dis_q, 2'h0, mw_ctl_q, 1'b0
    };

    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            rdata_q <= 32'h0000_0000;
        end else if (rd_hit) begin
            rdata_q <= rd_word;
        end else if (CFG_REQ.rd) begin
            rdata_q <= 32'h0000_0000;
        end
    end
    assign CFG_RDATA = rdata_q;

    wire live_mask = live_ins_q && !GPIO3_OE && GPIO3_IN;
    assign IO_EN_EFF     = IO_EN && !live_mask;
    assign MEM_EN_EFF    = MEM_EN && !live_mask;
    assign MASTER_EN_EFF = MASTER_EN && !live_mask;

    assign STEER.disc_cache_line = mw_ctl_q;
    wire plain_nopf = pf_dis_q && (RD_KIND == BDC_RD_PLAIN);
    assign STEER.prefetch     = !plain_nopf;
    assign STEER.fwd_byte_en  = plain_nopf;
    assign STEER.single_dword = plain_nopf;
    assign STEER.disc_first   = plain_nopf;

    always_comb begin
        case (bdc_test_mode_t'(test_mode_q))
            BDC_TM_ALL:   STEER.cnt_byte_sel = 4'hF;
            BDC_TM_BYTE1: STEER.cnt_byte_sel = 4'h2;
            BDC_TM_BYTE2: STEER.cnt_byte_sel = 4'h4;
            BDC_TM_BYTE0: STEER.cnt_byte_sel = 4'h1;
            default:      STEER.cnt_byte_sel = 4'hF;
        endcase
    end

    assign CHIP_RST    = chip_rst_q;
    assign SEC_RST_SET = rst_go;

endmodule : bdc_regs

// File: tb/bdc_host.sv
`timescale 1ns/10ps
module bdc_host
    import bdc_pkg::*;
(
    // Bus side
    input  wire logic        CORE_CLK,
    input  wire logic [31:0] CFG_RDATA,
    output bdc_cfg_req_t     CFG_REQ
);
    // Idle until the first request
    initial CFG_REQ = '0;
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [3:0] be, input logic [31:0] d, output logic [31:0] q);
        @(posedge CORE_CLK) #2;
        CFG_REQ = '{w, !w, a, be, d};
        @(posedge CORE_CLK) #2;
        // Released lines flip so stale values never look valid
        CFG_REQ = '{1'b0, 1'b0, ~a, ~be, ~d};
        q = CFG_RDATA;
    endtask : xfer
endmodule : bdc_host

// File: tb/bdc_regs_properties.sv
`timescale 1ns/10ps
module bdc_regs_properties
    import bdc_pkg::*;
#(
    parameter int RC = 10
) (
    // Clock and reset
    input wire logic         CORE_CLK,
    input wire logic         RESETN,
    // Access and steering
    input wire bdc_cfg_req_t CFG_REQ,
    input wire logic [31:0]  CFG_RDATA,
    input wire bdc_rd_kind_t RD_KIND,
    input wire bdc_steer_t   STEER,
    // Live insertion
    input wire logic         GPIO3_IN,
    input wire logic         GPIO3_OE,
    input wire logic         IO_EN,
    input wire logic         IO_EN_EFF,
    // Reset outputs
    input wire logic         CHIP_RST,
    input wire logic         SEC_RST_SET
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);
    wire rd40 = CFG_REQ.rd && CFG_REQ.addr == BDC_DWORD_ADDR;
    // Cycles in chip reset; a retrigger restarts it
    int cnt_q;
    always_ff @(posedge CORE_CLK)
        cnt_q <= SEC_RST_SET ? 0 : (CHIP_RST ? cnt_q + 1 : 0);
    mask_off_a: assert property (
        (!GPIO3_IN || GPIO3_OE) |-> IO_EN_EFF == IO_EN) else $error("masked");
    sec_pulse_a: assert property (SEC_RST_SET == (CFG_REQ.wr &&
        CFG_REQ.addr == 8'h40 && !CFG_REQ.cbe_n[1] && CFG_REQ.wdata[8]))
        else $error("sec pulse");
    rst_follow_a: assert property (
        SEC_RST_SET |=> CHIP_RST) else $error("no chip reset");
    rst_len_a: assert property (
        $fell(CHIP_RST) |-> cnt_q == RC) else $error("reset length");
    rst_bound_a: assert property (
        cnt_q <= RC) else $error("reset stuck");
    rd_other_a: assert property (
        CFG_REQ.rd && !rd40 |=> CFG_RDATA == 0) else $error("other addr");
    rd_resv_a: assert property (
        CFG_REQ.rd |=> !(CFG_RDATA & 32'hFFFFF8CD)) else $error("reserved");
    rd_live_a: assert property (
        rd40 |=> CFG_RDATA[8] == $past(CHIP_RST)) else $error("reset bit");
    pf_kind_a: assert property (
        RD_KIND != BDC_RD_PLAIN |-> STEER.prefetch) else $error("prefetch");
    // Main scenarios
    cover property (SEC_RST_SET);
    cover property ($fell(CHIP_RST));
    cover property (IO_EN && !IO_EN_EFF);
endmodule : bdc_regs_properties
bind bdc_regs bdc_regs_properties #(.RC(RST_CYCLES)) i_props (.*);

// File: tb/tb_top.sv
`timescale 1ns/10ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin \
    error_cnt++; $display("wrong value %s exp %h got %h", n, e, s); end end
module tb_top
    import bdc_pkg::*;
;
    localparam int RC = 4;
    logic CORE_CLK = 0, RESETN = 0, GPIO3_IN = 0, GPIO3_OE = 0;
    logic IO_EN = 0, MEM_EN = 0, MASTER_EN = 0;
    logic IO_EN_EFF, MEM_EN_EFF, MASTER_EN_EFF, CHIP_RST, SEC_RST_SET;
    logic [31:0] CFG_RDATA, q, m, d, msk;
    logic [3:0] be;
    bdc_cfg_req_t CFG_REQ;
    bdc_rd_kind_t RD_KIND = BDC_RD_PLAIN;
    bdc_steer_t STEER;
    int error_cnt = 0, check_count = 0, seed = 81431;
    // Clock, partner and design
    always #25 CORE_CLK = ~CORE_CLK;
    bdc_host i_host (.*);
    bdc_regs #(.RST_CYCLES(RC)) i_dut (.*);
    // Read back and compare the register, steering and enable outputs with the model
    task automatic chk_all(input logic [31:0] e);
        logic blk, pl;
        logic [3:0] sel;
        i_host.xfer(1'b0, 8'h40, 4'h0, 32'h0, q);
        blk = e[5] & GPIO3_IN & !GPIO3_OE;
        pl = e[4] && RD_KIND == BDC_RD_PLAIN;
        sel = e[10:9] == 0 ? 4'hF : 4'h1 << (e[10:9] % 3);
        `CHK("cfg", e, q)
        `CHK("steer", {e[1], !pl, pl, pl, pl, sel}, STEER)
        `CHK("en", {IO_EN, MEM_EN, MASTER_EN} & {3{!blk}}, {IO_EN_EFF, MEM_EN_EFF, MASTER_EN_EFF})
    endtask : chk_all
    task automatic complete_run;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : complete_run
    // Hang guard, far beyond the fewer than 100 cycles needed
    initial begin
        #200000;
        error_cnt++;
        complete_run;
    end
    // Random lane writes, then chip reset
    initial begin
        m = 0;
        repeat (5) @(posedge CORE_CLK);
        #2 RESETN = 1;
        chk_all(m);
        for (int i = 0; i < 14; i++) begin
            d = $random(seed) & ~32'h100;
            be = i == 13 ? 4'h0 : 4'($random(seed));
            msk = (be[0] ? 0 : 32'h32) | (be[1] ? 0 : 32'h600);
            i_host.xfer(1'b1, 8'h40, be, d, q);
            m = (m & ~msk) | (d & msk);
            {GPIO3_IN, GPIO3_OE, IO_EN, MEM_EN, MASTER_EN} = 5'($random(seed));
            RD_KIND = bdc_rd_kind_t'({$random(seed)} % 3);
            chk_all(m);
        end
        i_host.xfer(1'b0, 8'h44, 4'h0, 32'h0, q);
        `CHK("unmapped", 32'h0, q)
        i_host.xfer(1'b1, 8'h40, 4'hD, 32'hFFFFFFFF, q);
        i_host.xfer(1'b0, 8'h40, 4'h0, 32'h0, q);
        `CHK("in reset", 32'h100, q)
        repeat (RC) @(posedge CORE_CLK);
        chk_all(32'h0);
        complete_run;
    end
endmodule : tb_top
